/* src/temp_monitor_map.svh */
/*
  Register pointer values, power-on values and field masks of the
  temperature monitor register bank.
  Assumes the includer uses the values at their declared width: 8 bits, 12 for RST_TEMP.
*/
`ifndef TEMP_MONITOR_MAP_SVH
`define TEMP_MONITOR_MAP_SVH

// Pointer
`define PTR_RESET 8'h00
// Read pointers
`define RD_LOC_HI 8'h00
`define RD_REM_HI 8'h01
`define RD_STATUS 8'h02
`define RD_CONFIG 8'h03
`define RD_RATE 8'h04
`define RD_LOC_HLIM 8'h05
`define RD_LOC_LLIM 8'h06
`define RD_REM_HLIM_U 8'h07
`define RD_REM_LLIM_U 8'h08
`define RD_REM_LO 8'h10
`define RD_LOC_LO 8'h15
`define RD_MAKER 8'hFE
// Write pointers
`define WR_CONFIG 8'h09
`define WR_RATE 8'h0A
`define WR_LOC_HLIM 8'h0B
`define WR_LOC_LLIM 8'h0C
`define WR_REM_HLIM_U 8'h0D
`define WR_REM_LLIM_U 8'h0E
`define WR_ONE_SHOT 8'h0F
// Read and write at the same pointer
`define RW_OFS_U 8'h11
`define RW_OFS_L 8'h12
`define RW_REM_HLIM_L 8'h13
`define RW_REM_LLIM_L 8'h14
`define RW_REM_SHUT 8'h19
`define RW_LOC_SHUT 8'h20
`define RW_HYST 8'h21
`define RW_ALERT 8'h22
`define RW_IDEAL 8'h23
`define RW_FILTER 8'h24
// Power-on values
`define RST_ZERO 8'h00
`define RST_TEMP 12'h000
`define RST_CONFIG 8'h00
`define RST_RATE 8'h08
`define RST_LOC_HLIM 8'h55
`define RST_LOC_LLIM 8'h00
`define RST_REM_HLIM 8'h55
`define RST_REM_LLIM 8'h00
`define RST_REM_SHUT 8'h6C
`define RST_LOC_SHUT 8'h55
`define RST_HYST 8'h0A
`define RST_ALERT 8'h01
// Writable bits and fixed bits
`define MASK_CONFIG 8'hE4
`define MASK_RATE 8'h0F
`define MASK_NIBBLE 8'hF0
`define MASK_ALERT 8'h8E
`define FIXED_ALERT 8'h01
`define MASK_FILTER 8'h03

`endif

/* src/temp_monitor_pkg.sv */
/*
  Types shared by the temperature monitor register bank.
  Assumes the map header supplies the numeric values.
*/
package temp_monitor_pkg;

  typedef struct packed {
    logic ptr_load;    // First byte of a write: pointer
    logic wr_en;       // Later byte of a write: data
    logic rd_en;       // Byte fetched by a read
    logic [7:0] wdata; // Byte written by the host
  } bus_req_s;

  typedef struct packed {
    logic done;          // Measurement finished
    logic [11:0] local_t;
    logic [11:0] remote_t;
  } conv_s;

  typedef struct packed {
    logic [7:0] config_r;
    logic [7:0] rate;
    logic [7:0] loc_hlim;
    logic [7:0] loc_llim;
    logic [7:0] rem_hlim_u;
    logic [7:0] rem_llim_u;
    logic [7:0] rem_hlim_l;
    logic [7:0] rem_llim_l;
    logic [7:0] ofs_u;
    logic [7:0] ofs_l;
    logic [7:0] rem_shut;
    logic [7:0] loc_shut;
    logic [7:0] hyst;
    logic [7:0] alert;
    logic [7:0] ideal;
    logic [7:0] filter;
  } cfg_s;

  typedef enum {
    RK_OTHER,
    RK_HIGH,
    RK_LOW
  } read_kind_e;

endpackage

/* src/temp_monitor_register_map.sv */
/*
  Register bank of a local and remote temperature monitor: pointer,
  temperature results with byte-pair lock, limits, offset and setup.
  Assumes a serial protocol engine and converter on sys_clk deliver
  one-cycle strobes; limit compare and status flags live outside.
*/
// Behaviour
// - An 8-bit pointer chooses which register answers the next access.
// - Every write transaction loads the pointer from its first byte.
// - Pointer clears to zero at power-on reset.
// - Local result: upper eight bits at 00h, low four at 15h top nibble.
// - Remote result: upper eight bits at 01h, low four at 10h top nibble.
// - Low bits are sixteenths of a degree; low nibble of low bytes is zero.
// - High byte least significant bit weighs one degree Celsius.
// - Results are read-only and rewritten at each completed measurement.
// - Reading a high byte freezes its low byte until that is read.
// - Reading a low byte first freezes its high byte until read.
// - Reading any other register ends the pairing.
// - Every result register resets to zero.
// - Local high limit read 05 write 0B; low limit read 06 write 0C.
// - Remote high limit upper read 07 write 0D; lower nibble at 13.
// - Remote low limit upper read 08 write 0E; lower nibble at 14.
// - 12-bit remote offset at 11 and top nibble of 12, reset zero.
// - Pointer 0F write starts one conversion; data ignored, not readable.
// - Shutdown limits at 19 (resets 6C) and 20, same read/write address.
// - General call reset restores all registers and aborts conversion.
`timescale 1ns/10ps
`include "temp_monitor_map.svh"

module temp_monitor_register_map
  import temp_monitor_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3A // Arbitrary identity value
) (
  input wire logic sys_clk,          // 20 MHz clock
  input wire logic arst_n,           // Async reset, active low
  input wire bus_req_s bus_req,      // Strobes from protocol engine
  input wire logic soft_reset,       // General call reset byte seen
  input wire conv_s conv,            // Converter results
  input wire logic [7:0] status_in,  // Status flags from outside
  output logic [7:0] rd_data,        // Byte for the host
  output logic status_read,          // Status register was read
  output logic one_shot,             // Start one conversion
  output logic conv_abort,           // Abort running conversion
  output cfg_s cfg                   // Setup and limit registers
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic cfg_s cfg_reset();
    cfg_s c;
    c.config_r = `RST_CONFIG;
    c.rate = `RST_RATE;
    c.loc_hlim = `RST_LOC_HLIM;
    c.loc_llim = `RST_LOC_LLIM;
    c.rem_hlim_u = `RST_REM_HLIM;
    c.rem_llim_u = `RST_REM_LLIM;
    c.rem_hlim_l = `RST_ZERO;
    c.rem_llim_l = `RST_ZERO;
    c.ofs_u = `RST_ZERO;
    c.ofs_l = `RST_ZERO;
    c.rem_shut = `RST_REM_SHUT;
    c.loc_shut = `RST_LOC_SHUT;
    c.hyst = `RST_HYST;
    c.alert = `RST_ALERT;
    c.ideal = `RST_ZERO;
    c.filter = `RST_ZERO;
    return c;
  endfunction

  // Which byte of a channel a pointer names
  function automatic read_kind_e kind_of(
    input logic [7:0] ptr,
    input logic remote
  );
    read_kind_e k;
    k = RK_OTHER;
    if (ptr == (remote ? `RD_REM_HI : `RD_LOC_HI)) begin
      k = RK_HIGH;
    end
    if (ptr == (remote ? `RD_REM_LO : `RD_LOC_LO)) begin
      k = RK_LOW;
    end
    return k;
  endfunction

  // Low byte: four fraction bits on top, zeros below
  function automatic logic [7:0] low_byte(input logic [11:0] t);
    return {t[3:0], 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] pointer_reg;
  logic [7:0] pointer_next;
  cfg_s cfg_reg;
  cfg_s cfg_next;
  logic [1:0][11:0] temp_reg;
  logic [1:0][11:0] temp_next;
  logic [1:0] hi_lock_reg;
  logic [1:0] hi_lock_next;
  logic [1:0] lo_lock_reg;
  logic [1:0] lo_lock_next;
  logic [1:0] pend_reg;
  logic [1:0] pend_next;
  logic [1:0][11:0] pend_val_reg;
  logic [1:0][11:0] pend_val_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic status_read_reg;
  logic status_read_next;
  logic one_shot_reg;
  logic one_shot_next;
  logic conv_abort_reg;
  logic conv_abort_next;

  ////////////////////////////////////////////////////////////////////
  // Pointer and setup registers

  always_comb begin
    pointer_next = pointer_reg;
    cfg_next = cfg_reg;
    one_shot_next = 1'b0;
    if (bus_req.ptr_load) begin
      pointer_next = bus_req.wdata;
    end else if (bus_req.wr_en) begin
      case (pointer_reg)
        `WR_CONFIG: begin
          cfg_next.config_r = bus_req.wdata & `MASK_CONFIG;
        end
        `WR_RATE: begin
          cfg_next.rate = bus_req.wdata & `MASK_RATE;
        end
        `WR_LOC_HLIM: begin
          cfg_next.loc_hlim = bus_req.wdata;
        end
        `WR_LOC_LLIM: begin
          cfg_next.loc_llim = bus_req.wdata;
        end
        `WR_REM_HLIM_U: begin
          cfg_next.rem_hlim_u = bus_req.wdata;
        end
        `WR_REM_LLIM_U: begin
          cfg_next.rem_llim_u = bus_req.wdata;
        end
        `WR_ONE_SHOT: begin
          one_shot_next = 1'b1;
        end
        `RW_OFS_U: begin
          cfg_next.ofs_u = bus_req.wdata;
        end
        `RW_OFS_L: begin
          cfg_next.ofs_l = bus_req.wdata & `MASK_NIBBLE;
        end
        `RW_REM_HLIM_L: begin
          cfg_next.rem_hlim_l = bus_req.wdata & `MASK_NIBBLE;
        end
        `RW_REM_LLIM_L: begin
          cfg_next.rem_llim_l = bus_req.wdata & `MASK_NIBBLE;
        end
        `RW_REM_SHUT: begin
          cfg_next.rem_shut = bus_req.wdata;
        end
        `RW_LOC_SHUT: begin
          cfg_next.loc_shut = bus_req.wdata;
        end
        `RW_HYST: begin
          cfg_next.hyst = bus_req.wdata;
        end
        `RW_ALERT: begin
          cfg_next.alert = (bus_req.wdata & `MASK_ALERT) | `FIXED_ALERT;
        end
        `RW_IDEAL: begin
          cfg_next.ideal = bus_req.wdata;
        end
        `RW_FILTER: begin
          cfg_next.filter = bus_req.wdata & `MASK_FILTER;
        end
        default: begin
          // Read-only or unmapped pointer: write dropped
        end
      endcase
    end
    if (soft_reset) begin
      pointer_next = `PTR_RESET;
      cfg_next = cfg_reset();
      one_shot_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pointer_reg <= `PTR_RESET;
      cfg_reg <= cfg_reset();
      one_shot_reg <= 1'b0;
    end else begin
      pointer_reg <= pointer_next;
      cfg_reg <= cfg_next;
      one_shot_reg <= one_shot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Temperature results with byte-pair lock

  always_comb begin
    read_kind_e k;
    logic [11:0] v;
    k = RK_OTHER;
    v = `RST_TEMP;
    temp_next = temp_reg;
    hi_lock_next = hi_lock_reg;
    lo_lock_next = lo_lock_reg;
    pend_next = pend_reg;
    pend_val_next = pend_val_reg;
    for (int c = 0; c < 2; c++) begin
      k = kind_of(pointer_reg, c[0]);
      v = (c == 0) ? conv.local_t : conv.remote_t;
      if (bus_req.rd_en) begin
        case (k)
          RK_HIGH: begin
            if (hi_lock_reg[c]) begin
              hi_lock_next[c] = 1'b0;
            end else begin
              lo_lock_next[c] = 1'b1;
            end
          end
          RK_LOW: begin
            if (lo_lock_reg[c]) begin
              lo_lock_next[c] = 1'b0;
            end else begin
              hi_lock_next[c] = 1'b1;
            end
          end
          default: begin
            hi_lock_next[c] = 1'b0;
            lo_lock_next[c] = 1'b0;
          end
        endcase
      end
      // Catch up with a result held back while locked
      if (pend_reg[c] && !hi_lock_next[c] && !lo_lock_next[c]) begin
        temp_next[c] = pend_val_reg[c];
        pend_next[c] = 1'b0;
      end
      if (conv.done) begin
        if (lo_lock_next[c]) begin
          temp_next[c][11:4] = v[11:4];
          pend_next[c] = 1'b1;
          pend_val_next[c] = v;
        end else if (hi_lock_next[c]) begin
          temp_next[c][3:0] = v[3:0];
          pend_next[c] = 1'b1;
          pend_val_next[c] = v;
        end else begin
          temp_next[c] = v;
          pend_next[c] = 1'b0;
        end
      end
    end
    if (soft_reset) begin
      temp_next = {2{`RST_TEMP}};
      hi_lock_next = 2'b00;
      lo_lock_next = 2'b00;
      pend_next = 2'b00;
      pend_val_next = {2{`RST_TEMP}};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_reg <= {2{`RST_TEMP}};
      hi_lock_reg <= 2'b00;
      lo_lock_reg <= 2'b00;
      pend_reg <= 2'b00;
      pend_val_reg <= {2{`RST_TEMP}};
    end else begin
      temp_reg <= temp_next;
      hi_lock_reg <= hi_lock_next;
      lo_lock_reg <= lo_lock_next;
      pend_reg <= pend_next;
      pend_val_reg <= pend_val_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data and side strobes

  always_comb begin
    rd_data_next = rd_data_reg;
    status_read_next = 1'b0;
    conv_abort_next = soft_reset;
    if (bus_req.rd_en) begin
      case (pointer_reg)
        `RD_LOC_HI: begin
          rd_data_next = temp_reg[0][11:4];
        end
        `RD_REM_HI: begin
          rd_data_next = temp_reg[1][11:4];
        end
        `RD_LOC_LO: begin
          rd_data_next = low_byte(temp_reg[0]);
        end
        `RD_REM_LO: begin
          rd_data_next = low_byte(temp_reg[1]);
        end
        `RD_STATUS: begin
          rd_data_next = status_in;
          status_read_next = 1'b1;
        end
        `RD_CONFIG: begin
          rd_data_next = cfg_reg.config_r;
        end
        `RD_RATE: begin
          rd_data_next = cfg_reg.rate;
        end
        `RD_LOC_HLIM: begin
          rd_data_next = cfg_reg.loc_hlim;
        end
        `RD_LOC_LLIM: begin
          rd_data_next = cfg_reg.loc_llim;
        end
        `RD_REM_HLIM_U: begin
          rd_data_next = cfg_reg.rem_hlim_u;
        end
        `RD_REM_LLIM_U: begin
          rd_data_next = cfg_reg.rem_llim_u;
        end
        `RW_OFS_U: begin
          rd_data_next = cfg_reg.ofs_u;
        end
        `RW_OFS_L: begin
          rd_data_next = cfg_reg.ofs_l;
        end
        `RW_REM_HLIM_L: begin
          rd_data_next = cfg_reg.rem_hlim_l;
        end
        `RW_REM_LLIM_L: begin
          rd_data_next = cfg_reg.rem_llim_l;
        end
        `RW_REM_SHUT: begin
          rd_data_next = cfg_reg.rem_shut;
        end
        `RW_LOC_SHUT: begin
          rd_data_next = cfg_reg.loc_shut;
        end
        `RW_HYST: begin
          rd_data_next = cfg_reg.hyst;
        end
        `RW_ALERT: begin
          rd_data_next = cfg_reg.alert;
        end
        `RW_IDEAL: begin
          rd_data_next = cfg_reg.ideal;
        end
        `RW_FILTER: begin
          rd_data_next = cfg_reg.filter;
        end
        `RD_MAKER: begin
          rd_data_next = MAKER_ID;
        end
        default: begin
          rd_data_next = `RST_ZERO; // One-shot and unmapped
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= `RST_ZERO;
      status_read_reg <= 1'b0;
      conv_abort_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      status_read_reg <= status_read_next;
      conv_abort_reg <= conv_abort_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign status_read = status_read_reg;
  assign one_shot = one_shot_reg;
  assign conv_abort = conv_abort_reg;
  assign cfg = cfg_reg;

endmodule

/* test/temp_monitor_register_map_assertions.sv */
/*
  Concurrent checks on the register bank ports.
  Assumes single clock domain, bound to the design top.
*/
`timescale 1ns/10ps

module temp_monitor_checker
  import temp_monitor_pkg::*;
(
  input wire logic sys_clk,         // Clock
  input wire logic arst_n,          // Async reset, active low
  input wire bus_req_s bus_req,     // Host strobes
  input wire logic soft_reset,      // General call reset
  input wire conv_s conv,           // Converter results
  input wire logic [7:0] status_in, // Outside status flags
  input wire logic [7:0] rd_data,   // Read byte
  input wire logic status_read,     // Status read pulse
  input wire logic one_shot,        // Conversion start pulse
  input wire logic conv_abort,      // Abort pulse
  input wire cfg_s cfg              // Setup registers
);
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic wr_ok;

  ////////////////////////////////////////////////////////////////
  // Shadow pointer
  assign wr_ok = bus_req.wr_en && !bus_req.ptr_load && !soft_reset;
  always_comb begin
    ptr_next = ptr_reg;
    if (soft_reset) begin
      ptr_next = 8'h00;
    end else if (bus_req.ptr_load) begin
      ptr_next = bus_req.wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= 8'h00;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_os_req;
    wr_ok && ptr_reg == 8'h0F;
  endsequence
  sequence s_os_pulse;
    one_shot ##1 !one_shot;
  endsequence

  chk_one_shot_go: assert property (s_os_req |=> s_os_pulse)
    else $error("one-shot write gave no single pulse");
  chk_one_shot_cause: assert property (one_shot |-> $past(wr_ok) && $past(ptr_reg) == 8'h0F)
    else $error("one-shot pulse without its write");
  chk_unread_trigger: assert property (bus_req.rd_en && !soft_reset && ptr_reg == 8'h0F
    |=> rd_data == 8'h00)
    else $error("trigger address read non-zero");
  chk_status_read: assert property (bus_req.rd_en && !soft_reset && ptr_reg == 8'h02 |=> status_read)
    else $error("status read pulse missing");
  chk_status_cause: assert property (status_read |-> $past(bus_req.rd_en))
    else $error("status pulse without read");
  chk_abort_pulse: assert property (soft_reset |=> conv_abort ##1 !conv_abort)
    else $error("abort not a single pulse");
  chk_shut_restore: assert property (soft_reset |=> cfg.rem_shut == 8'h6C && cfg.loc_shut == 8'h55)
    else $error("shutdown limits not restored");
  chk_hlim_write: assert property (wr_ok && ptr_reg == 8'h0B |=> cfg.loc_hlim == $past(bus_req.wdata))
    else $error("local high limit write lost");
  chk_ro_write: assert property (wr_ok && ptr_reg inside {8'h00, 8'h01, 8'h02, 8'h05, 8'h10, 8'h15}
    |=> $stable(cfg))
    else $error("read-only write changed setup");
  chk_rd_hold: assert property (!bus_req.rd_en |=> $stable(rd_data))
    else $error("read byte changed without read");
endmodule

bind temp_monitor_register_map temp_monitor_checker chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .soft_reset(soft_reset), .conv(conv),
  .status_in(status_in), .rd_data(rd_data), .status_read(status_read), .one_shot(one_shot),
  .conv_abort(conv_abort), .cfg(cfg)
);

/* test/host_model.sv */
/*
  Host side model: issues pointer, write and read strobes.
  Assumes strobes change at the falling edge of sys_clk.
*/
`timescale 1ns/10ps

module host_model
  import temp_monitor_pkg::*;
(
  input wire logic sys_clk,       // Clock
  input wire logic [7:0] rd_data, // Byte from the device
  output bus_req_s bus_req        // Strobes to the device
);
  initial bus_req = '0;

  // Pointer byte first in every write
  task setp(input logic [7:0] p);
    @(negedge sys_clk);
    bus_req.ptr_load = 1'b1;
    bus_req.wdata = p;
    @(negedge sys_clk);
    bus_req.ptr_load = 1'b0;
  endtask

  task wr(input logic [7:0] p, input logic [7:0] d);
    setp(p);
    bus_req.wr_en = 1'b1;
    bus_req.wdata = d;
    @(negedge sys_clk);
    bus_req.wr_en = 1'b0;
    bus_req.wdata = ~d;
  endtask

  task rd(output logic [7:0] d);
    @(negedge sys_clk);
    bus_req.rd_en = 1'b1;
    @(negedge sys_clk);
    bus_req.rd_en = 1'b0;
    d = rd_data;
  endtask
endmodule

/* test/tb_temp_monitor_register_map.sv */
/*
  Self-checking bench of the temperature monitor register bank.
  Assumes host_model drives the strobes; the bench drives the rest.
*/
`timescale 1ns/10ps

module tb_temp_monitor_register_map;
  import temp_monitor_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic soft_reset = 1'b0;
  conv_s conv = '0;
  logic [7:0] status_in = 8'h5C;
  bus_req_s bus_req;
  logic [7:0] rd_data;
  logic status_read;
  logic one_shot;
  logic conv_abort;
  cfg_s cfg;
  logic [7:0] d;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #25 sys_clk = ~sys_clk;

  temp_monitor_register_map dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .soft_reset(soft_reset), .conv(conv),
    .status_in(status_in), .rd_data(rd_data), .status_read(status_read), .one_shot(one_shot),
    .conv_abort(conv_abort), .cfg(cfg)
  );
  host_model host_u (.sys_clk(sys_clk), .rd_data(rd_data), .bus_req(bus_req));

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t pulse got %b expected %b", $time, got, exp);
    end
  endtask

  task rchk(input logic [7:0] p, input logic [7:0] exp);
    host_u.setp(p);
    host_u.rd(d);
    chk8(d, exp);
  endtask

  task conv_go(input logic [11:0] l, input logic [11:0] r);
    @(negedge sys_clk);
    conv = {1'b1, l, r};
    @(negedge sys_clk);
    conv.done = 1'b0;
  endtask

  task wrap_up;
    $display("Errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_power_on;
    logic [7:0] rp [8];
    logic [7:0] rv [8];
    rp = '{8'h19, 8'h20, 8'h21, 8'h22, 8'h04, 8'h05, 8'h07, 8'h11};
    rv = '{8'h6C, 8'h55, 8'h0A, 8'h01, 8'h08, 8'h55, 8'h55, 8'h00};
    conv_go(12'h3C5, 12'h000);
    host_u.rd(d);
    chk8(d, 8'h3C);
    for (int i = 0; i < 8; i++) begin
      rchk(rp[i], rv[i]);
    end
  endtask

  task t_temps;
    conv_go(12'h0A1, 12'h7F3);
    rchk(8'h00, 8'h0A);
    rchk(8'h15, 8'h10);
    rchk(8'h01, 8'h7F);
    rchk(8'h10, 8'h30);
  endtask

  task t_lock;
    conv_go(12'h111, 12'h222);
    rchk(8'h00, 8'h11);
    conv_go(12'h333, 12'h444);
    rchk(8'h15, 8'h10);
    rchk(8'h00, 8'h33);
    rchk(8'h15, 8'h30);
    rchk(8'h10, 8'h40);
    conv_go(12'h555, 12'h666);
    rchk(8'h01, 8'h44);
    rchk(8'h10, 8'h60);
    rchk(8'h00, 8'h55);
    rchk(8'h03, 8'h00);
    conv_go(12'h777, 12'h888);
    rchk(8'h15, 8'h70);
  endtask

  task t_limits;
    logic [7:0] wp [10];
    logic [7:0] rq [10];
    logic [7:0] v;
    wp = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20};
    rq = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20};
    for (int i = 0; i < 10; i++) begin
      v = 8'hA5 + 8'(i);
      host_u.wr(wp[i], v);
      rchk(rq[i], (wp[i] inside {8'h12, 8'h13, 8'h14}) ? (v & 8'hF0) : v);
    end
    chk8(cfg.loc_hlim, 8'hA5);
    chk8(cfg.ofs_u, 8'hA9);
    host_u.wr(8'h09, 8'hFF);
    rchk(8'h03, 8'hE4);
    host_u.wr(8'h0A, 8'hFF);
    rchk(8'h04, 8'h0F);
    host_u.wr(8'h22, 8'h00);
    rchk(8'h22, 8'h01);
    host_u.wr(8'h24, 8'hFF);
    rchk(8'h24, 8'h03);
    // Identity byte is the arbitrary default of the design parameter
    host_u.wr(8'hFE, 8'h00);
    rchk(8'hFE, 8'h3A);
  endtask

  task t_read_only;
    logic [7:0] rp [6];
    logic [7:0] rv [6];
    rp = '{8'h00, 8'h15, 8'h01, 8'h10, 8'h05, 8'h02};
    rv = '{8'h77, 8'h70, 8'h88, 8'h80, 8'hA5, 8'h5C};
    for (int i = 0; i < 6; i++) begin
      host_u.wr(rp[i], 8'hFF);
    end
    for (int i = 0; i < 6; i++) begin
      rchk(rp[i], rv[i]);
    end
    host_u.wr(8'h0F, 8'h3C);
    chk1(one_shot, 1'b1);
    rchk(8'h0F, 8'h00);
    chk1(one_shot, 1'b0);
    chk1(status_read, 1'b0);
    rchk(8'h02, 8'h5C);
    chk1(status_read, 1'b1);
  endtask

  task t_soft_reset;
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
    chk1(conv_abort, 1'b1);
    host_u.rd(d);
    chk1(conv_abort, 1'b0);
    chk8(d, 8'h00);
    rchk(8'h15, 8'h00);
    rchk(8'h01, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h05, 8'h55);
    chk8(cfg.rem_shut, 8'h6C);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    t_power_on();
    t_temps();
    t_lock();
    t_limits();
    t_read_only();
    t_soft_reset();
    wrap_up();
  end
endmodule
